// ==== rtl/vic_pkg.sv ====
// Purpose: Shared constants and types for the vectored interrupt command registers
// Assumes: 32-bit classic Wishbone, byte addresses on a 10-bit bus
// Notes: All offsets are word aligned
package vic_pkg;
  // Data width and source count
  localparam int VIC_DW = 32;
  localparam int VIC_NSRC = 32;
  localparam int VIC_AW = 10;
  // Vector table occupies the first 32 words
  localparam logic [9:0] VIC_OFS_SVR = 10'h000;
  localparam logic [9:0] VIC_OFS_SVR_END = 10'h080;
  // Vector, status and command registers
  localparam logic [9:0] VIC_OFS_IVR = 10'h100;
  localparam logic [9:0] VIC_OFS_FVR = 10'h104;
  localparam logic [9:0] VIC_OFS_CUR = 10'h108;
  localparam logic [9:0] VIC_OFS_PEND = 10'h10C;
  localparam logic [9:0] VIC_OFS_MASK = 10'h110;
  localparam logic [9:0] VIC_OFS_CORE = 10'h114;
  localparam logic [9:0] VIC_OFS_MEN = 10'h120;
  localparam logic [9:0] VIC_OFS_MDIS = 10'h124;
  localparam logic [9:0] VIC_OFS_CLR = 10'h128;
  localparam logic [9:0] VIC_OFS_SET = 10'h12C;
  localparam logic [9:0] VIC_OFS_EOS = 10'h130;
  localparam logic [9:0] VIC_OFS_SPU = 10'h134;
  localparam logic [9:0] VIC_OFS_DBG = 10'h138;
  localparam logic [9:0] VIC_OFS_FFEN = 10'h140;
  localparam logic [9:0] VIC_OFS_FFDIS = 10'h144;
  localparam logic [9:0] VIC_OFS_FFST = 10'h148;
  localparam logic [9:0] VIC_OFS_EVST = 10'h150;
  localparam logic [9:0] VIC_OFS_EVCLR = 10'h154;
  localparam logic [9:0] VIC_OFS_EVEN = 10'h158;
  // Reset values
  localparam logic [31:0] VIC_SPU_RST = 32'h00000000;
  localparam logic [1:0] VIC_DBG_RST = 2'h0;
  localparam logic [31:0] VIC_VEC_RST = 32'h00000000;
  // Debug control field positions
  localparam int VIC_DBG_PROTECTION_MODE_BIT = 0;
  localparam int VIC_DBG_GLOBAL_MASK_BIT = 1;
  // Fast source sits at bit 0
  localparam int VIC_FAST_SRC = 0;
  // Block event bits
  localparam int VIC_EVT_N = 3;
  localparam int VIC_EVT_IVR_SPUR = 0;
  localparam int VIC_EVT_FVR_SPUR = 1;
  localparam int VIC_EVT_EOS_IDLE = 2;
  // Bus handshake states
  typedef enum logic [1:0] {
    VIC_ST_IDLE = 2'b00,
    VIC_ST_WAIT = 2'b01,
    VIC_ST_ACK = 2'b10
  } vic_bus_st_t;
  // Lowest set bit: {found, index}
  function automatic logic [5:0] vic_lowest(input logic [31:0] v);
    logic [5:0] r;
    r = 6'h00;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 5'(i)};
      end
    end
    return r;
  endfunction
  // Byte lane select to bit mask
  function automatic logic [31:0] vic_bytemask(input logic [3:0] sel);
    return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction
endpackage

// ==== rtl/vic_vec_mem.sv ====
// Purpose: Source vector table, one word per source, registered read
// Assumes: Single clock, clock enable freezes both ports
// Notes: Byte lanes honoured on write
`timescale 1ns/1ps
`default_nettype none
module vic_vec_mem #(
  parameter int DW = 32,
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW/8-1:0] wsel,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [DEPTH]; // Vector words

  // Write with byte lanes; vectors clear on reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= vic_pkg::VIC_VEC_RST;
      end
    end else if (ce && we) begin
      for (int b = 0; b < DW/8; b++) begin
        if (wsel[b]) begin
          mem[waddr][b*8 +: 8] <= wdata[b*8 +: 8];
        end
      end
    end
  end

  // Registered read port
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= '0;
    end else if (ce) begin
      rdata <= mem[raddr];
    end
  end
endmodule
`default_nettype wire

// ==== rtl/vic_events.sv ====
// Purpose: Sticky block events with enable and write-one clear
// Assumes: Event inputs are one-cycle pulses
// Notes: A set in the clearing cycle wins
`timescale 1ns/1ps
`default_nettype none
module vic_events #(
  parameter int N = 3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [N-1:0] evt,
  input wire logic clr_we,
  input wire logic en_we,
  input wire logic [N-1:0] wdata,
  output logic [N-1:0] status,
  output logic [N-1:0] enable,
  output logic irq
);
  // Sticky status, set beats clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status <= '0;
    end else if (ce) begin
      status <= (status & ~(clr_we ? wdata : '0)) | evt;
    end
  end

  // Enable register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      enable <= '0;
    end else if (ce && en_we) begin
      enable <= wdata;
    end
  end

  // Level output from a flop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(status & enable);
    end
  end
endmodule
`default_nettype wire

// ==== rtl/vic_cmd_regs.sv ====
// Purpose: Command and control registers of a vectored interrupt controller
// Assumes: Classic Wishbone slave, MCLK 50 MHz, RST asynchronous active high
// Notes: Answers every access two cycles after the request is seen
// Function
// - Clear command ones drop pending sources
// - Set command ones force sources pending
// - Any end-of-service write ends current service
// - Spurious vector returned on spurious vector reads
// - Debug bit 0 selects protection mode
// - Debug bit 1 holds both lines inactive
// - Fast enable ones route source to fast
// - Fast disable ones return source to normal
// - Fast status shows forcing per source
// - Fast forcing excludes bit 0 fast source
// - Normal vector read indexes table by lowest normal candidate
// - No current interrupt gives spurious vector
// - Fast vector read gives source 0 vector
`timescale 1ns/1ps
`default_nettype none
module vic_cmd_regs #(
  parameter int NSRC = 32
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [9:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  input wire logic [NSRC-1:0] SRC_IRQ,
  output logic NORMAL_INTR_LINE_N,
  output logic FAST_INTR_LINE_N,
  output logic EVT_IRQ
);
  vic_pkg::vic_bus_st_t st; // Bus handshake state
  logic [9:0] adr_q; // Latched address
  logic we_q; // Latched direction
  logic [3:0] sel_q; // Latched byte lanes
  logic [31:0] dat_w; // Latched write data
  logic cand_ok_q; // Normal candidate found at request
  logic [4:0] cand_q; // Normal candidate index
  logic [31:0] pending; // Pending sources
  logic [31:0] mask; // Enabled sources
  logic [31:0] ff; // Fast forcing, bit 0 always zero
  logic [31:0] spu; // Spurious handler address
  logic [1:0] dbg; // Protection and global mask
  logic cur_valid; // A normal source is in service
  logic [4:0] cur_src; // Source in service
  logic irq_q; // Normal line active
  logic fiq_q; // Fast line active
  logic [31:0] mem_rdata; // Vector table read data
  logic [4:0] mem_raddr; // Vector table read index
  logic [2:0] evt_status; // Block event status
  logic [2:0] evt_enable; // Block event enable
  logic [2:0] evt; // Block event pulses

  // Derived combinational terms
  logic [31:0] cand_vec;
  logic [5:0] cand;
  logic fiq_act;
  logic commit;
  logic [31:0] dat_m;
  logic wr_clr, wr_set, wr_eos, wr_spu, wr_dbg, wr_ffen, wr_ffdis;
  logic wr_men, wr_mdis, wr_ivr, wr_svr, wr_evclr, wr_even;
  logic rd_ivr, rd_fvr;
  logic ivr_take, fvr_take;
  logic [31:0] clr_mask;
  logic [31:0] set_mask;
  logic protection_mode_bit, global_mask_bit;

  assign protection_mode_bit = dbg[vic_pkg::VIC_DBG_PROTECTION_MODE_BIT];
  assign global_mask_bit = dbg[vic_pkg::VIC_DBG_GLOBAL_MASK_BIT];
  // Normal candidates: enabled, pending, not forced, not the fast source
  assign cand_vec = pending & mask & ~ff & ~32'h00000001;
  assign cand = vic_pkg::vic_lowest(cand_vec);
  // Fast line: source 0 or any forced source
  assign fiq_act = (pending[vic_pkg::VIC_FAST_SRC] & mask[vic_pkg::VIC_FAST_SRC]) |
                   (|(pending & mask & ff));
  assign commit = CE && (st == vic_pkg::VIC_ST_WAIT);
  assign dat_m = dat_w & vic_pkg::vic_bytemask(sel_q);
  assign wr_clr = commit && we_q && (adr_q == vic_pkg::VIC_OFS_CLR);
  assign wr_set = commit && we_q && (adr_q == vic_pkg::VIC_OFS_SET);
  assign wr_eos = commit && we_q && (adr_q == vic_pkg::VIC_OFS_EOS);
  assign wr_spu = commit && we_q && (adr_q == vic_pkg::VIC_OFS_SPU);
  assign wr_dbg = commit && we_q && (adr_q == vic_pkg::VIC_OFS_DBG);
  assign wr_ffen = commit && we_q && (adr_q == vic_pkg::VIC_OFS_FFEN);
  assign wr_ffdis = commit && we_q && (adr_q == vic_pkg::VIC_OFS_FFDIS);
  assign wr_men = commit && we_q && (adr_q == vic_pkg::VIC_OFS_MEN);
  assign wr_mdis = commit && we_q && (adr_q == vic_pkg::VIC_OFS_MDIS);
  assign wr_ivr = commit && we_q && (adr_q == vic_pkg::VIC_OFS_IVR);
  assign wr_evclr = commit && we_q && (adr_q == vic_pkg::VIC_OFS_EVCLR);
  assign wr_even = commit && we_q && (adr_q == vic_pkg::VIC_OFS_EVEN);
  assign wr_svr = commit && we_q && (adr_q < vic_pkg::VIC_OFS_SVR_END);
  assign rd_ivr = commit && !we_q && (adr_q == vic_pkg::VIC_OFS_IVR);
  assign rd_fvr = commit && !we_q && (adr_q == vic_pkg::VIC_OFS_FVR);
  // Protected reads only look; an IVR write then does the normal update
  assign ivr_take = protection_mode_bit ? wr_ivr : rd_ivr;
  assign fvr_take = rd_fvr && !protection_mode_bit && fiq_act;
  // Clear sources: command, or acknowledge by vector read (for IVR, by an IVR write when protected)
  assign clr_mask = (wr_clr ? dat_m : 32'h00000000) |
                    ((ivr_take && cand_ok_q) ? (32'h00000001 << cand_q) : 32'h00000000) |
                    (fvr_take ? 32'h00000001 : 32'h00000000);
  assign set_mask = (wr_set ? dat_m : 32'h00000000) | SRC_IRQ;
  // Block events
  assign evt[vic_pkg::VIC_EVT_IVR_SPUR] = rd_ivr && !cand_ok_q;
  assign evt[vic_pkg::VIC_EVT_FVR_SPUR] = rd_fvr && !fiq_act;
  assign evt[vic_pkg::VIC_EVT_EOS_IDLE] = wr_eos && !cur_valid;
  assign ACK_O = (st == vic_pkg::VIC_ST_ACK);
  assign NORMAL_INTR_LINE_N = !irq_q;
  assign FAST_INTR_LINE_N = !fiq_q;

  // Vector table read index follows the live request
  always_comb begin
    if (ADR_I == vic_pkg::VIC_OFS_IVR) begin
      mem_raddr = cand[4:0];
    end else if (ADR_I == vic_pkg::VIC_OFS_FVR) begin
      mem_raddr = 5'h00;
    end else begin
      mem_raddr = ADR_I[6:2];
    end
  end

  // Bus handshake: idle, wait for table, acknowledge
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      st <= vic_pkg::VIC_ST_IDLE;
    end else if (CE) begin
      unique case (st)
        vic_pkg::VIC_ST_IDLE: begin
          if (CYC_I && STB_I) begin
            st <= vic_pkg::VIC_ST_WAIT;
          end
        end
        vic_pkg::VIC_ST_WAIT: begin
          st <= vic_pkg::VIC_ST_ACK;
        end
        vic_pkg::VIC_ST_ACK: begin
          st <= vic_pkg::VIC_ST_IDLE;
        end
        default: begin
          st <= vic_pkg::VIC_ST_IDLE;
        end
      endcase
    end
  end

  // Request capture
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      adr_q <= 10'h000;
      we_q <= 1'b0;
      sel_q <= 4'h0;
      dat_w <= 32'h00000000;
      cand_ok_q <= 1'b0;
      cand_q <= 5'h00;
    end else if (CE && st == vic_pkg::VIC_ST_IDLE && CYC_I && STB_I) begin
      adr_q <= ADR_I;
      we_q <= WE_I;
      sel_q <= SEL_I;
      dat_w <= DAT_I;
      cand_ok_q <= cand[5];
      cand_q <= cand[4:0];
    end
  end

  // Pending sources, set wins over clear
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      pending <= 32'h00000000;
    end else if (CE) begin
      pending <= (pending & ~clr_mask) | set_mask;
    end
  end

  // Source enable commands
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      mask <= 32'h00000000;
    end else if (wr_men) begin
      mask <= mask | dat_m;
    end else if (wr_mdis) begin
      mask <= mask & ~dat_m;
    end
  end

  // Fast forcing; bit 0 never stored
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ff <= 32'h00000000;
    end else if (wr_ffen) begin
      ff <= (ff | dat_m) & ~32'h00000001;
    end else if (wr_ffdis) begin
      ff <= ff & ~dat_m & ~32'h00000001;
    end
  end

  // Spurious vector and debug control
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      spu <= vic_pkg::VIC_SPU_RST;
      dbg <= vic_pkg::VIC_DBG_RST;
    end else begin
      if (wr_spu) begin
        spu <= (spu & ~vic_pkg::vic_bytemask(sel_q)) | dat_m;
      end
      if (wr_dbg && sel_q[0]) begin
        dbg <= dat_w[1:0];
      end
    end
  end

  // Current source in service
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      cur_valid <= 1'b0;
      cur_src <= 5'h00;
    end else if (wr_eos) begin
      cur_valid <= 1'b0;
    end else if (ivr_take && cand_ok_q) begin
      cur_valid <= 1'b1;
      cur_src <= cand_q;
    end
  end

  // Core lines, held inactive under the global mask
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      irq_q <= 1'b0;
      fiq_q <= 1'b0;
    end else if (CE) begin
      irq_q <= !global_mask_bit && cand[5] && !cur_valid;
      fiq_q <= !global_mask_bit && fiq_act;
    end
  end

  // Read data, loaded as the answer is formed
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      DAT_O <= 32'h00000000;
    end else if (commit && !we_q) begin
      if (adr_q < vic_pkg::VIC_OFS_SVR_END) begin
        DAT_O <= mem_rdata;
      end else begin
        case (adr_q)
          vic_pkg::VIC_OFS_IVR: DAT_O <= cand_ok_q ? mem_rdata : spu;
          vic_pkg::VIC_OFS_FVR: DAT_O <= fiq_act ? mem_rdata : spu;
          vic_pkg::VIC_OFS_CUR: DAT_O <= {27'h0000000, cur_src};
          vic_pkg::VIC_OFS_PEND: DAT_O <= pending;
          vic_pkg::VIC_OFS_MASK: DAT_O <= mask;
          vic_pkg::VIC_OFS_CORE: DAT_O <= {30'h00000000, irq_q, fiq_q};
          vic_pkg::VIC_OFS_SPU: DAT_O <= spu;
          vic_pkg::VIC_OFS_DBG: DAT_O <= {30'h00000000, dbg};
          vic_pkg::VIC_OFS_FFST: DAT_O <= ff;
          vic_pkg::VIC_OFS_EVST: DAT_O <= {29'h00000000, evt_status};
          vic_pkg::VIC_OFS_EVEN: DAT_O <= {29'h00000000, evt_enable};
          // Write-only and unmapped read zero
          default: DAT_O <= 32'h00000000;
        endcase
      end
    end
  end

  // Source vector table
  vic_vec_mem #(
    .DW(32),
    .DEPTH(32),
    .AW(5)
  ) u_vec (
    .clk(MCLK),
    .rst(RST),
    .ce(CE),
    .we(wr_svr),
    .waddr(adr_q[6:2]),
    .wsel(sel_q),
    .wdata(dat_w),
    .raddr(mem_raddr),
    .rdata(mem_rdata)
  );

  // Block event status and interrupt
  vic_events #(
    .N(vic_pkg::VIC_EVT_N)
  ) u_evt (
    .clk(MCLK),
    .rst(RST),
    .ce(CE),
    .evt(evt),
    .clr_we(wr_evclr),
    .en_we(wr_even),
    .wdata(dat_w[2:0]),
    .status(evt_status),
    .enable(evt_enable),
    .irq(EVT_IRQ)
  );

  // Checks
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  a_clear_cmd: assert property (wr_clr |=> (pending & $past(dat_m & ~SRC_IRQ)) == 32'h0)
    else $error("clear command left a source pending");
  a_set_cmd: assert property (wr_set |=> (pending & $past(dat_m)) == $past(dat_m))
    else $error("set command did not force pending");
  a_eos_ends: assert property (wr_eos |=> !cur_valid ##1 !ACK_O)
    else $error("end of service left source in service");
  a_spur_ivr: assert property (rd_ivr && !cand_ok_q |=> DAT_O == $past(spu) && ACK_O)
    else $error("spurious normal read wrong");
  a_ivr_vec: assert property (rd_ivr && cand_ok_q |=> DAT_O == $past(mem_rdata))
    else $error("normal vector read wrong");
  a_fvr_vec: assert property (rd_fvr |=> DAT_O == ($past(fiq_act) ? $past(mem_rdata) : $past(spu)))
    else $error("fast vector read wrong");
  a_protection_mode_bit_read: assert property (rd_ivr && protection_mode_bit |=> $stable(cur_valid) && $stable(cur_src))
    else $error("protected read changed service state");
  a_gmask_lines: assert property (global_mask_bit && CE |=> NORMAL_INTR_LINE_N && FAST_INTR_LINE_N)
    else $error("global mask did not hold lines");
  a_ff_enable: assert property (wr_ffen |=> (ff[31:1] & $past(dat_m[31:1])) == $past(dat_m[31:1]))
    else $error("fast enable not applied");
  a_ff_disable: assert property (wr_ffdis |=> (ff & $past(dat_m)) == 32'h0)
    else $error("fast disable not applied");
  a_ff_status: assert property (commit && !we_q && adr_q == vic_pkg::VIC_OFS_FFST |=> DAT_O == $past(ff) && !DAT_O[0])
    else $error("fast status read wrong");
  a_protection_mode_bit_select: assert property (wr_dbg && sel_q[0] |=> protection_mode_bit == $past(dat_w[0]))
    else $error("protection bit not written");
  a_dbg_reserved: assert property (commit && !we_q && adr_q == vic_pkg::VIC_OFS_DBG |=> DAT_O[31:2] == 30'h0)
    else $error("debug reserved bits nonzero");
  // Earliest following commit is three cycles on: wait, acknowledge, idle take
  a_spu_read: assert property (wr_spu && sel_q == 4'hF ##[3:4] (commit && !we_q && adr_q == vic_pkg::VIC_OFS_SPU) |=> DAT_O == $past(spu))
    else $error("spurious vector not held");
  a_ack_pulse: assert property (ACK_O && CE |=> !ACK_O)
    else $error("acknowledge held too long");

  c_ivr_take: cover property (ivr_take && cand_ok_q ##[1:20] wr_eos);
  c_spur_read: cover property (rd_ivr && !cand_ok_q);
  c_fast_forced: cover property (!FAST_INTR_LINE_N && ff != 32'h0);
  c_protection_mode_bit_write: cover property (protection_mode_bit && wr_ivr && cand_ok_q);
  // Fast vector read that acknowledges source 0
  c_fast_take: cover property (fvr_take);
endmodule
`default_nettype wire

// ==== verification/vic_core_model.sv ====
// Purpose: Behavioural stand-in for the processor core's two interrupt inputs
// Assumes: Both lines are active low levels sampled on the master clock
// Notes: Counts each new assertion so the bench can judge line activity
`timescale 1ns/1ps
`default_nettype none
module vic_core_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic normal_n,
  input wire logic fast_n,
  output logic [7:0] normal_cnt,
  output logic [7:0] fast_cnt
);
  logic normal_q; // Previous normal line level
  logic fast_q; // Previous fast line level
  // Onset counter: a high-to-low step is one request taken by the core
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      normal_q <= 1'b1;
      fast_q <= 1'b1;
      normal_cnt <= 8'h00;
      fast_cnt <= 8'h00;
    end else begin
      normal_q <= normal_n;
      fast_q <= fast_n;
      if (normal_q && !normal_n) begin
        normal_cnt <= normal_cnt + 8'h01;
      end
      if (fast_q && !fast_n) begin
        fast_cnt <= fast_cnt + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ==== verification/vic_cmd_regs_tb_top.sv ====
// Purpose: Self-checking bench for the interrupt command registers
// Assumes: Classic Wishbone master, 50 MHz clock, reset held 8 cycles
// Notes: Each test is a list of bus calls with expected values
`timescale 1ns/1ps
`default_nettype none
module vic_cmd_regs_tb_top;
  logic MCLK = 1'b0;
  logic RST = 1'b1;
  logic CE = 1'b1; // Clock enable, held on except for one cycle in the fast test
  logic CYC_I = 1'b0;
  logic STB_I = 1'b0;
  logic WE_I = 1'b0;
  logic [9:0] ADR_I = 10'h000;
  logic [3:0] SEL_I = 4'h0;
  logic [31:0] DAT_I = 32'h00000000;
  logic [31:0] SRC_IRQ = 32'h00000000;
  logic [31:0] DAT_O;
  logic ACK_O;
  logic NORMAL_INTR_LINE_N;
  logic FAST_INTR_LINE_N;
  logic EVT_IRQ;
  logic [7:0] ncnt; // Normal onsets seen by the core
  logic [7:0] fcnt; // Fast onsets seen by the core
  int fails = 0;
  int n_compared = 0;
  // Clock at 20 ns period
  always #10 MCLK = ~MCLK;
  vic_cmd_regs dut_u (.MCLK(MCLK), .RST(RST), .CE(CE), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I),
    .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .SRC_IRQ(SRC_IRQ),
    .NORMAL_INTR_LINE_N(NORMAL_INTR_LINE_N), .FAST_INTR_LINE_N(FAST_INTR_LINE_N), .EVT_IRQ(EVT_IRQ));
  vic_core_model core_u (.clk(MCLK), .rst(RST), .normal_n(NORMAL_INTR_LINE_N), .fast_n(FAST_INTR_LINE_N),
    .normal_cnt(ncnt), .fast_cnt(fcnt));
  // Expected handler address of a source
  function automatic logic [31:0] vec(input int i);
    return 32'h10000000 + 32'(i * 4);
  endfunction
  // Single comparison point
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One classic cycle, held until ack is sampled; only the watchdog ends a hang
  task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d, output logic [31:0] q);
    CYC_I <= 1'b1;
    STB_I <= 1'b1;
    WE_I <= w;
    ADR_I <= a;
    DAT_I <= d;
    SEL_I <= 4'hF;
    do begin
      @(posedge MCLK);
    end while (ACK_O !== 1'b1);
    q = DAT_O;
    CYC_I <= 1'b0;
    STB_I <= 1'b0;
    @(posedge MCLK);
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rdchk(input logic [9:0] a, input logic [31:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 32'h00000000, q);
    chk(q, e);
  endtask
  // Line levels looked at mid-cycle, once settled
  task automatic lines(input logic n, input logic f, input logic e);
    @(negedge MCLK);
    chk({NORMAL_INTR_LINE_N, FAST_INTR_LINE_N, EVT_IRQ}, {n, f, e});
    @(posedge MCLK);
  endtask
  task automatic tdone(input string s);
    $display("test %s done", s);
  endtask
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Watchdog: whole sequence needs well under 2000 cycles
  initial begin
    #100000;
    fails++;
    finish_test;
  end
  // Main sequence
  initial begin
    repeat (8) @(posedge MCLK);
    RST <= 1'b0;
    @(posedge MCLK);
    rdchk(vic_pkg::VIC_OFS_SPU, 32'h00000000);
    rdchk(vic_pkg::VIC_OFS_DBG, 32'h00000000);
    rdchk(vic_pkg::VIC_OFS_FFST, 32'h00000000);
    lines(1'b1, 1'b1, 1'b0);
    tdone("reset");
    wr(vic_pkg::VIC_OFS_SPU, 32'hA5A50F0F);
    rdchk(vic_pkg::VIC_OFS_SPU, 32'hA5A50F0F);
    wr(vic_pkg::VIC_OFS_DBG, 32'hFFFFFFFF);
    rdchk(vic_pkg::VIC_OFS_DBG, 32'h00000003);
    wr(vic_pkg::VIC_OFS_DBG, 32'h00000000);
    wr(10'h3F0, 32'hFFFFFFFF);
    rdchk(10'h3F0, 32'h00000000);
    rdchk(vic_pkg::VIC_OFS_CLR, 32'h00000000);
    for (int i = 0; i < 32; i++) begin
      wr(vic_pkg::VIC_OFS_SVR + 10'(i * 4), vec(i));
    end
    rdchk(vic_pkg::VIC_OFS_SVR + 10'h07C, vec(31));
    wr(vic_pkg::VIC_OFS_MEN, 32'hFFFFFFFF);
    tdone("registers");
    wr(vic_pkg::VIC_OFS_SET, 32'h00000024);
    rdchk(vic_pkg::VIC_OFS_PEND, 32'h00000024);
    lines(1'b0, 1'b1, 1'b0);
    wr(vic_pkg::VIC_OFS_CLR, 32'h00000004);
    rdchk(vic_pkg::VIC_OFS_PEND, 32'h00000020);
    wr(vic_pkg::VIC_OFS_DBG, 32'h00000002);
    lines(1'b1, 1'b1, 1'b0);
    wr(vic_pkg::VIC_OFS_DBG, 32'h00000000);
    lines(1'b0, 1'b1, 1'b0);
    rdchk(vic_pkg::VIC_OFS_IVR, vec(5));
    rdchk(vic_pkg::VIC_OFS_CUR, 32'h00000005);
    wr(vic_pkg::VIC_OFS_EOS, 32'hDEADBEEF);
    rdchk(vic_pkg::VIC_OFS_EVST, 32'h00000000);
    wr(vic_pkg::VIC_OFS_EOS, 32'h00000000);
    rdchk(vic_pkg::VIC_OFS_EVST, 32'h00000004);
    tdone("pending");
    rdchk(vic_pkg::VIC_OFS_IVR, 32'hA5A50F0F);
    rdchk(vic_pkg::VIC_OFS_FVR, 32'hA5A50F0F);
    rdchk(vic_pkg::VIC_OFS_EVST, 32'h00000007);
    wr(vic_pkg::VIC_OFS_EVEN, 32'h00000007);
    lines(1'b1, 1'b1, 1'b1);
    wr(vic_pkg::VIC_OFS_EVCLR, 32'h00000007);
    lines(1'b1, 1'b1, 1'b0);
    wr(vic_pkg::VIC_OFS_SET, 32'h00000001);
    lines(1'b1, 1'b0, 1'b0);
    rdchk(vic_pkg::VIC_OFS_FVR, vec(0));
    tdone("spurious");
    wr(vic_pkg::VIC_OFS_DBG, 32'h00000001);
    wr(vic_pkg::VIC_OFS_SET, 32'h00000008);
    rdchk(vic_pkg::VIC_OFS_IVR, vec(3));
    rdchk(vic_pkg::VIC_OFS_IVR, vec(3));
    rdchk(vic_pkg::VIC_OFS_PEND, 32'h00000008);
    wr(vic_pkg::VIC_OFS_IVR, 32'h00000000);
    rdchk(vic_pkg::VIC_OFS_CUR, 32'h00000003);
    rdchk(vic_pkg::VIC_OFS_PEND, 32'h00000000);
    wr(vic_pkg::VIC_OFS_EOS, 32'h00000000);
    wr(vic_pkg::VIC_OFS_DBG, 32'h00000000);
    tdone("protect");
    wr(vic_pkg::VIC_OFS_FFEN, 32'hFFFFFFFF);
    rdchk(vic_pkg::VIC_OFS_FFST, 32'hFFFFFFFE);
    wr(vic_pkg::VIC_OFS_SET, 32'h00000080);
    lines(1'b1, 1'b0, 1'b0);
    chk({24'h000000, fcnt}, 32'h00000002);
    wr(vic_pkg::VIC_OFS_FFDIS, 32'h00000080);
    rdchk(vic_pkg::VIC_OFS_FFST, 32'hFFFFFF7E);
    lines(1'b0, 1'b1, 1'b0);
    wr(vic_pkg::VIC_OFS_FFDIS, 32'hFFFFFFFF);
    rdchk(vic_pkg::VIC_OFS_FFST, 32'h00000000);
    wr(vic_pkg::VIC_OFS_CLR, 32'hFFFFFFFF);
    SRC_IRQ <= 32'h00000200;
    @(posedge MCLK);
    SRC_IRQ <= 32'h00000000;
    rdchk(vic_pkg::VIC_OFS_PEND, 32'h00000200);
    wr(vic_pkg::VIC_OFS_CLR, 32'h00000200);
    rdchk(vic_pkg::VIC_OFS_PEND, 32'h00000000);
    chk({24'h000000, ncnt}, 32'h00000005);
    // Clock enable low: a source request must not be taken
    CE <= 1'b0;
    SRC_IRQ <= 32'h00000010;
    @(posedge MCLK);
    SRC_IRQ <= 32'h00000000;
    CE <= 1'b1;
    @(posedge MCLK);
    rdchk(vic_pkg::VIC_OFS_PEND, 32'h00000000);
    tdone("fast");
    finish_test;
  end
endmodule
`default_nettype wire
